// File: rtl/peilp_top.sv
// Top of the PHY LED, event interrupt and deep sleep register block
`timescale 1ns/1ps
module peilp_top import peilp_pkg::*; (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_mdc,
   input wire logic i_mdio_in,
   output logic o_mdio_out,
   output logic o_mdio_oe_n,
   input wire logic [4:0] i_phy_addr,
   input wire logic [1:0] i_bank_sel,
   input wire peilp_lstat_type i_lstat,
   input wire logic i_rmii_mode,
   input wire logic i_rx_err,
   input wire logic [10:0] i_evt_cond,
   input wire logic i_in_deep_sleep,
   output logic [3:0] o_led,
   output logic [3:0] o_aux_led_ctl,
   output logic o_irq_out,
   output logic o_irq_oe_n,
   output logic [5:0] o_fifo_thresh,
   output logic o_deep_sleep,
   output logic o_pll_off,
   output logic o_rx100_off,
   output logic o_dac_off,
   output logic o_cdr_off
);

   // ***********************************************
   // Decoding helpers
   // ***********************************************
   function automatic logic reg_sel(
      input logic [4:0] addr,
      input logic [1:0] bank,
      input logic [4:0] ofs
   );
      reg_sel = (bank != BANK_ONE) && (addr == ofs);
   endfunction : reg_sel

   function automatic logic led_drive(
      input logic [2:0] code,
      input peilp_lstat_type s,
      input logic zeroth
   );
      logic v;
      v = 1'b0;
      case (code)
         LED_LINK: v = s.link;
         LED_ACT: v = s.act;
         LED_TX: v = s.tx;
         LED_RX: v = s.rx;
         LED_SPEED: v = s.speed100;
         LED_FDX: v = s.fdx;
         LED_OFF: v = zeroth ? s.link : 1'b0;
         default: v = 1'b0;
      endcase
      led_drive = v;
   endfunction : led_drive

   // ***********************************************
   // Declarations
   // ***********************************************
   peilp_mreq_type req;
   logic hit;
   logic [15:0] rdata;
   logic wr_led;
   logic wr_rxerr;
   logic wr_ictl;
   logic wr_iflag;
   logic wr_pwr;
   logic rd_iflag;
   logic [15:0] led_q;
   logic [15:0] rxerr_q;
   logic [15:0] rxerr_base;
   logic rxerr_inc;
   logic [15:0] ictl_q;
   logic [10:0] flag_q;
   logic [10:0] cond_q;
   logic [15:0] pwr_q;
   logic pend;
   logic [5:0] thr_sum;

   // ***********************************************
   // Management access
   // ***********************************************
   peilp_mdio u_mdio (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_mdc(i_mdc),
      .i_mdio_in(i_mdio_in),
      .i_phy_addr(i_phy_addr),
      .i_hit(hit),
      .i_rdata(rdata),
      .o_mdio_out(o_mdio_out),
      .o_mdio_oe_n(o_mdio_oe_n),
      .o_req(req)
   );

   assign wr_led = req.wr && reg_sel(req.addr, i_bank_sel, OFS_LED);
   assign wr_rxerr = req.wr && reg_sel(req.addr, i_bank_sel, OFS_RXERR);
   assign wr_ictl = req.wr && reg_sel(req.addr, i_bank_sel, OFS_ICTL);
   assign wr_iflag = req.wr && reg_sel(req.addr, i_bank_sel, OFS_IFLAG);
   assign wr_pwr = req.wr && reg_sel(req.addr, i_bank_sel, OFS_PWR);
   assign rd_iflag = req.rd && reg_sel(req.addr, i_bank_sel, OFS_IFLAG);

   // Bank one and other addresses belong to other blocks, so stay silent
   always_comb begin
      hit = 1'b1;
      rdata = 16'h0000;
      if (reg_sel(req.addr, i_bank_sel, OFS_LED)) begin
         rdata = led_q;
      end else if (reg_sel(req.addr, i_bank_sel, OFS_RXERR)) begin
         rdata = rxerr_q;
      end else if (reg_sel(req.addr, i_bank_sel, OFS_ICTL)) begin
         rdata = ictl_q;
      end else if (reg_sel(req.addr, i_bank_sel, OFS_IFLAG)) begin
         rdata = {5'h00, flag_q};
      end else if (reg_sel(req.addr, i_bank_sel, OFS_PWR)) begin
         rdata = pwr_q;
      end else begin
         hit = 1'b0;
      end
   end

   // ***********************************************
   // LED source selection
   // ***********************************************
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         led_q <= RST_LED;
      end else if (wr_led) begin
         led_q <= req.wdata;
      end
   end

   genvar gl;
   generate
      for (gl = 0; gl < NUM_LED; gl++) begin : g_led
         always_ff @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
               o_led[gl] <= 1'b0;
            end else begin
               o_led[gl] <= led_drive(led_q[gl*LED_W +: LED_W],
                                      i_lstat, gl == 0);
            end
         end
      end
   endgenerate

   // Upper nibble is kept for the neighbouring LED and pad logic
   assign o_aux_led_ctl = led_q[15:12];

   // ***********************************************
   // Receive error counter
   // ***********************************************
   // Saturates rather than wraps so software never sees a false low
   assign rxerr_inc = i_rx_err & i_rmii_mode;
   assign rxerr_base = wr_rxerr ? req.wdata : rxerr_q;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rxerr_q <= RST_RXERR;
      end else if (rxerr_inc && rxerr_base != 16'hffff) begin
         rxerr_q <= rxerr_base + 16'h0001;
      end else begin
         rxerr_q <= rxerr_base;
      end
   end

   // ***********************************************
   // Interrupt control
   // ***********************************************
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ictl_q <= RST_ICTL;
      end else if (wr_ictl) begin
         ictl_q <= req.wdata;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cond_q <= 11'h000;
      end else begin
         cond_q <= i_evt_cond;
      end
   end

   // ***********************************************
   // Event flags
   // ***********************************************
   // A flag sets on the rising edge of its condition, so a write clear
   // with ICTL_RESETUP low can drop it while the condition is still present.
   genvar ge;
   generate
      for (ge = 0; ge < NUM_EVT; ge++) begin : g_flag
         logic set;
         logic clr_rd;
         logic clr_wr;
         logic clr_auto;
         assign set = i_evt_cond[ge] & ~cond_q[ge];
         assign clr_rd = rd_iflag && ictl_q[ICTL_RDCLR] &&
                         flag_q[ge];
         assign clr_wr = wr_iflag && req.wdata[ge] &&
                         !(ictl_q[ICTL_RESETUP] &&
                           i_evt_cond[ge]);
         assign clr_auto = ictl_q[ICTL_AUTO] && !i_evt_cond[ge];
         always_ff @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
               flag_q[ge] <= RST_IFLAG[ge];
            end else if (set) begin
               flag_q[ge] <= 1'b1;
            end else if (clr_rd || clr_wr || clr_auto) begin
               flag_q[ge] <= 1'b0;
            end
         end
      end
   endgenerate

   // ***********************************************
   // Interrupt pin
   // ***********************************************
   assign pend = |(flag_q & ictl_q[NUM_EVT-1:0]);

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq_out <= 1'b1;
         o_irq_oe_n <= 1'b1;
      end else begin
         o_irq_out <= pend ? ictl_q[ICTL_POL] : ~ictl_q[ICTL_POL];
         o_irq_oe_n <= ~ictl_q[ICTL_OE];
      end
   end

   // ***********************************************
   // FIFO threshold and deep sleep
   // ***********************************************
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         pwr_q <= RST_PWR;
      end else if (wr_pwr) begin
         pwr_q <= req.wdata & PWR_WMASK;
      end
   end

   // Widest field value still fits, so the doubled sum never overflows
   assign thr_sum = {2'h0, pwr_q[PWR_FIFO_LSB +: 4]} + FIFO_BIAS;

   // Gating only applies once the sleep logic reports deep sleep
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_fifo_thresh <= 6'h00;
         o_deep_sleep <= 1'b0;
         o_pll_off <= 1'b0;
         o_rx100_off <= 1'b0;
         o_dac_off <= 1'b0;
         o_cdr_off <= 1'b0;
      end else begin
         o_fifo_thresh <= {thr_sum[4:0], 1'b0};
         o_deep_sleep <= pwr_q[PWR_DEEP];
         o_pll_off <= pwr_q[PWR_DEEP] && i_in_deep_sleep &&
                      pwr_q[PWR_PLL];
         o_rx100_off <= pwr_q[PWR_DEEP] && i_in_deep_sleep &&
                        pwr_q[PWR_RX];
         o_dac_off <= pwr_q[PWR_DEEP] && i_in_deep_sleep &&
                      pwr_q[PWR_DAC];
         o_cdr_off <= pwr_q[PWR_DEEP] && i_in_deep_sleep &&
                      pwr_q[PWR_CDR];
      end
   end

endmodule : peilp_top

// File: rtl/peilp_pkg.sv
// Constants and types of the PHY LED, event and power register block
package peilp_pkg;

   // ***********************************************
   // Register map
   // ***********************************************
   localparam logic [4:0] OFS_LED = 5'h14;
   localparam logic [4:0] OFS_RXERR = 5'h15;
   localparam logic [4:0] OFS_ICTL = 5'h16;
   localparam logic [4:0] OFS_IFLAG = 5'h17;
   localparam logic [4:0] OFS_PWR = 5'h18;
   localparam logic [15:0] RST_LED = 16'h3fe9;
   localparam logic [15:0] RST_RXERR = 16'h0000;
   localparam logic [15:0] RST_ICTL = 16'h0000;
   localparam logic [10:0] RST_IFLAG = 11'h000;
   localparam logic [15:0] RST_PWR = 16'h2000;
   localparam logic [15:0] PWR_WMASK = 16'hfff0;
   localparam logic [1:0] BANK_ONE = 2'h1;

   // ***********************************************
   // Field positions
   // ***********************************************
   localparam int LED_W = 3;
   localparam int NUM_LED = 4;
   localparam int ICTL_OE = 15;
   localparam int ICTL_RDCLR = 14;
   localparam int ICTL_POL = 13;
   localparam int ICTL_AUTO = 12;
   localparam int ICTL_RESETUP = 11;
   localparam int NUM_EVT = 11;
   localparam int PWR_FIFO_LSB = 12;
   localparam int PWR_DEEP = 8;
   localparam int PWR_PLL = 7;
   localparam int PWR_RX = 6;
   localparam int PWR_DAC = 5;
   localparam int PWR_CDR = 4;
   localparam logic [5:0] FIFO_BIAS = 6'h03;

   // ***********************************************
   // LED source codes
   // ***********************************************
   localparam logic [2:0] LED_LINK = 3'h0;
   localparam logic [2:0] LED_ACT = 3'h1;
   localparam logic [2:0] LED_TX = 3'h2;
   localparam logic [2:0] LED_RX = 3'h3;
   localparam logic [2:0] LED_SPEED = 3'h5;
   localparam logic [2:0] LED_FDX = 3'h6;
   localparam logic [2:0] LED_OFF = 3'h7;

   // ***********************************************
   // Management frame
   // ***********************************************
   localparam logic [5:0] MF_PRE = 6'h20;
   localparam logic [5:0] MF_HDR_LAST = 6'h0d;
   localparam logic [5:0] MF_TA_LAST = 6'h01;
   localparam logic [5:0] MF_DATA_LAST = 6'h0f;
   localparam logic [1:0] MF_ST = 2'h1;
   localparam logic [1:0] MF_OP_RD = 2'h2;
   localparam logic [1:0] MF_OP_WR = 2'h1;

   typedef enum logic [4:0] {
      MS_PRE = 5'h01,
      MS_HDR = 5'h02,
      MS_TA = 5'h04,
      MS_RDAT = 5'h08,
      MS_WDAT = 5'h10
   } peilp_mstate_type;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] addr;
      logic [15:0] wdata;
   } peilp_mreq_type;

   typedef struct packed {
      logic link;
      logic act;
      logic tx;
      logic rx;
      logic speed100;
      logic fdx;
   } peilp_lstat_type;

endpackage : peilp_pkg

// File: rtl/peilp_mdio.sv
// Management serial frame engine of the PHY LED, event and power block
`timescale 1ns/1ps
module peilp_mdio import peilp_pkg::*; (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_mdc,
   input wire logic i_mdio_in,
   input wire logic [4:0] i_phy_addr,
   input wire logic i_hit,
   input wire logic [15:0] i_rdata,
   output logic o_mdio_out,
   output logic o_mdio_oe_n,
   output peilp_mreq_type o_req
);

   peilp_mstate_type st_q;
   logic mdc_q;
   logic rise;
   logic [5:0] cnt_q;
   logic [15:0] sh_q;
   logic [13:0] hdr;
   logic rd_q;
   logic wr_q;
   logic isrd_q;
   logic own_q;
   logic [4:0] addr_q;
   logic [15:0] tx_q;

   assign rise = i_mdc & ~mdc_q;
   assign hdr = {sh_q[12:0], i_mdio_in};
   assign o_req = '{rd: rd_q, wr: wr_q, addr: addr_q, wdata: sh_q};

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         mdc_q <= 1'b0;
      end else begin
         mdc_q <= i_mdc;
      end
   end

   // ***********************************************
   // Frame receiver; a full preamble is needed per frame
   // ***********************************************
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= MS_PRE;
         cnt_q <= 6'h00;
         sh_q <= 16'h0000;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         isrd_q <= 1'b0;
         addr_q <= 5'h00;
      end else begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         if (rise) begin
            sh_q <= {sh_q[14:0], i_mdio_in};
            cnt_q <= cnt_q + 6'h01;
            unique case (st_q)
               MS_PRE: begin
                  if (i_mdio_in) begin
                     if (cnt_q == MF_PRE) cnt_q <= MF_PRE;
                  end else if (cnt_q == MF_PRE) begin
                     st_q <= MS_HDR;
                     cnt_q <= 6'h01;
                  end else begin
                     cnt_q <= 6'h00;
                  end
               end
               MS_HDR: begin
                  if (cnt_q == MF_HDR_LAST) begin
                     cnt_q <= 6'h00;
                     st_q <= MS_PRE;
                     if (hdr[13:12] == MF_ST && hdr[9:5] == i_phy_addr &&
                         (hdr[11:10] == MF_OP_RD ||
                          hdr[11:10] == MF_OP_WR)) begin
                        st_q <= MS_TA;
                        addr_q <= hdr[4:0];
                        isrd_q <= (hdr[11:10] == MF_OP_RD);
                        rd_q <= (hdr[11:10] == MF_OP_RD);
                     end
                  end
               end
               MS_TA: begin
                  if (cnt_q == MF_TA_LAST) begin
                     cnt_q <= 6'h00;
                     st_q <= isrd_q ? MS_RDAT : MS_WDAT;
                  end
               end
               MS_RDAT: begin
                  if (cnt_q == MF_DATA_LAST) begin
                     cnt_q <= 6'h00;
                     st_q <= MS_PRE;
                  end
               end
               MS_WDAT: begin
                  if (cnt_q == MF_DATA_LAST) begin
                     cnt_q <= 6'h00;
                     st_q <= MS_PRE;
                     wr_q <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // ***********************************************
   // Read data driver; silent when another block owns the address
   // ***********************************************
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_q <= 16'h0000;
         own_q <= 1'b0;
         o_mdio_out <= 1'b1;
         o_mdio_oe_n <= 1'b1;
      end else if (rd_q) begin
         tx_q <= i_rdata;
         own_q <= i_hit;
      end else if (rise) begin
         if (st_q == MS_TA && cnt_q == 6'h00) begin
            o_mdio_out <= 1'b0;
            o_mdio_oe_n <= ~own_q;
         end else if (st_q == MS_TA || (st_q == MS_RDAT &&
                      cnt_q != MF_DATA_LAST)) begin
            o_mdio_out <= tx_q[15];
            tx_q <= {tx_q[14:0], 1'b0};
         end else begin
            o_mdio_out <= 1'b1;
            o_mdio_oe_n <= 1'b1;
            own_q <= 1'b0;
         end
      end
   end

endmodule : peilp_mdio

// File: verif/peilp_top_checker.sv
// Port timing checks of the LED, event and sleep register block
`timescale 1ns/1ps
module peilp_top_checker (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_mdc,
   input wire logic [1:0] i_bank_sel,
   input wire logic [10:0] i_evt_cond,
   input wire logic i_in_deep_sleep,
   input wire logic o_mdio_out,
   input wire logic o_mdio_oe_n,
   input wire logic o_irq_out,
   input wire logic o_irq_oe_n,
   input wire logic [5:0] o_fifo_thresh,
   input wire logic o_deep_sleep,
   input wire logic o_pll_off,
   input wire logic o_rx100_off,
   input wire logic o_dac_off,
   input wire logic o_cdr_off
);
   // ****************
   // Activity tracking
   // ****************
   logic [2:0] quiet_q;
   logic [10:0] cond_q;
   logic mdc_q;
   logic any_off;
   assign any_off = o_pll_off | o_rx100_off | o_dac_off | o_cdr_off;
   // Saturates so that a long idle stretch cannot wrap to a small count
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         quiet_q <= 3'h0;
      end else if (i_mdc != mdc_q || i_evt_cond != cond_q) begin
         quiet_q <= 3'h0;
      end else if (quiet_q != 3'h7) begin
         quiet_q <= quiet_q + 3'h1;
      end
   end
   always_ff @(posedge i_core_clk) begin
      mdc_q <= i_mdc;
      cond_q <= i_evt_cond;
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   a_reset_quiet:
      assert property ($past(i_rst) |-> o_irq_oe_n && !o_deep_sleep)
      else $error("pin or sleep active after reset");
   a_bank_silent:
      assert property (i_bank_sel == 2'h1 |-> o_mdio_oe_n)
      else $error("data line driven in bank one");
   a_ta_zero:
      assert property ($fell(o_mdio_oe_n) |-> !o_mdio_out)
      else $error("turnaround bit not zero");
   a_read_holds:
      assert property ($fell(o_mdio_oe_n) |=> !o_mdio_oe_n [*5])
      else $error("read drive dropped early");
   a_thresh_legal:
      assert property (!$past(i_rst) |-> !o_fifo_thresh[0] &&
         o_fifo_thresh >= 6'h06 && o_fifo_thresh <= 6'h24)
      else $error("fifo threshold out of range");
   a_sleep_deep:
      assert property (any_off |-> o_deep_sleep &&
         $past(i_in_deep_sleep))
      else $error("block off without deep sleep");
   a_irq_cause:
      assert property ($changed(o_irq_out) |-> quiet_q < 3'h6)
      else $error("interrupt pin moved without cause");
   a_cfg_cause:
      assert property ($changed(o_deep_sleep) || $changed(o_irq_oe_n)
         |-> quiet_q < 3'h6)
      else $error("setting moved outside a frame");
endmodule : peilp_top_checker

bind peilp_top peilp_top_checker chk_u (.i_core_clk, .i_rst, .i_mdc,
   .i_bank_sel, .i_evt_cond, .i_in_deep_sleep, .o_mdio_out, .o_mdio_oe_n,
   .o_irq_out, .o_irq_oe_n, .o_fifo_thresh, .o_deep_sleep, .o_pll_off,
   .o_rx100_off, .o_dac_off, .o_cdr_off);

// File: verif/peilp_sta_model.sv
// Station management controller model for the management serial bus
`timescale 1ns/1ps
module peilp_sta_model #(
   parameter logic [4:0] PHY = 5'h05
) (
   input wire logic i_core_clk,
   input wire logic i_mdio,
   output logic o_mdc,
   output logic o_mdio,
   output logic o_mdio_en
);
   // ****************
   // Frame tasks
   // ****************
   initial begin
      o_mdc = 1'b0;
      o_mdio = 1'b1;
      o_mdio_en = 1'b0;
   end
   // Three core clocks per half bit; the device needs one to see a rise
   task automatic bit_cyc(input logic v, output logic o);
      o_mdio = v;
      repeat (3) @(negedge i_core_clk);
      o_mdc = 1'b1;
      repeat (3) @(negedge i_core_clk);
      o = i_mdio;
      o_mdc = 1'b0;
   endtask : bit_cyc
   // Full preamble every frame; clock stands low between frames
   task automatic xfer(input logic rd, input logic [4:0] ra,
      input logic [15:0] wd, output logic [15:0] rdat);
      logic [63:0] f;
      logic o;
      f = {32'hffffffff, 2'h1, rd ? 2'h2 : 2'h1, PHY, ra, 2'h2, wd};
      rdat = 16'h0000;
      @(negedge i_core_clk);
      o_mdio_en = 1'b1;
      for (int i = 63; i >= 0; i--) begin
         if (rd && i == 17) o_mdio_en = 1'b0;
         bit_cyc(f[i], o);
         if (rd && i >= 1 && i <= 16) rdat[i - 1] = o;
      end
      o_mdio_en = 1'b0;
   endtask : xfer
endmodule : peilp_sta_model

// File: verif/tb_peilp_top.sv
// Self-checking bench of the LED, event interrupt and sleep block
`timescale 1ns/1ps
module tb_peilp_top import peilp_pkg::*; ;
   // ****************
   // Bench signals and tasks
   // ****************
   localparam logic [4:0] PHY = 5'h05;
   logic clk = 1'b0;
   logic rst, mdc, m_out, m_en, mdio_w, mdio_out, mdio_oe_n;
   logic rmii, rx_err, in_sleep, irq_out, irq_oe_n, deep;
   logic [1:0] bank;
   logic [10:0] evt;
   logic [3:0] led, offs, aux;
   logic [5:0] thr;
   peilp_lstat_type ls;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   int i, j;
   logic [2:0] codes [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
   logic [5:0] pats [3] = '{6'h2a, 6'h19, 6'h07};
   logic [15:0] pw [4] = '{16'hf1ff, 16'h00f0, 16'h0100, 16'h11a0};
   logic [3:0] po [4] = '{4'hf, 4'h0, 4'h0, 4'ha};
   always #25 clk = ~clk;
   // Line has a pull-up, so a silent device reads as ones
   assign mdio_w = !mdio_oe_n ? mdio_out : (m_en ? m_out : 1'b1);
   peilp_top dut_u (.i_core_clk(clk), .i_rst(rst), .i_mdc(mdc),
      .i_mdio_in(mdio_w), .o_mdio_out(mdio_out), .o_mdio_oe_n(mdio_oe_n),
      .i_phy_addr(PHY), .i_bank_sel(bank), .i_lstat(ls), .i_rmii_mode(rmii),
      .i_rx_err(rx_err), .i_evt_cond(evt), .i_in_deep_sleep(in_sleep),
      .o_led(led), .o_aux_led_ctl(aux), .o_irq_out(irq_out),
      .o_irq_oe_n(irq_oe_n), .o_fifo_thresh(thr), .o_deep_sleep(deep),
      .o_pll_off(offs[3]), .o_rx100_off(offs[2]), .o_dac_off(offs[1]),
      .o_cdr_off(offs[0]));
   peilp_sta_model #(.PHY(PHY)) sta_u (.i_core_clk(clk), .i_mdio(mdio_w),
      .o_mdc(mdc), .o_mdio(m_out), .o_mdio_en(m_en));
   task automatic check(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t mismatch got %h exp %h", $time, g, e);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] r;
      sta_u.xfer(1'b0, a, d, r);
      tick(3);
   endtask : wr
   task automatic rdc(input logic [4:0] a, input logic [15:0] e);
      logic [15:0] r;
      sta_u.xfer(1'b1, a, 16'h0000, r);
      check(r, e);
   endtask : rdc
   task automatic pulse(input int k);
      evt[k] = 1'b1;
      tick(3);
      evt[k] = 1'b0;
      tick(3);
   endtask : pulse
   task automatic errs(input logic m, input int n);
      rmii = m;
      rx_err = 1'b1;
      tick(n);
      rx_err = 1'b0;
   endtask : errs
   function automatic logic led_f(input logic [2:0] c, input logic z);
      case (c)
         3'h0: return ls.link;
         3'h1: return ls.act;
         3'h2: return ls.tx;
         3'h3: return ls.rx;
         3'h4: return 1'b0;
         3'h5: return ls.speed100;
         3'h6: return ls.fdx;
         default: return z & ls.link;
      endcase
   endfunction : led_f
   task final_report;
      if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   // Ceiling is about half again the length of the sequence below
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      rst = 1'b1;
      bank = 2'h0;
      ls = pats[0];
      rmii = 1'b0;
      rx_err = 1'b0;
      evt = 11'h000;
      in_sleep = 1'b1;
      tick(6);
      rst = 1'b0;
      tick(2);
      check({10'h000, thr}, 16'h000a);
      check({8'h00, aux, led}, 16'h0032);
      rdc(OFS_LED, {4'h3, 3'h7, 3'h7, 3'h5, 3'h1});
      rdc(OFS_RXERR, 16'h0000);
      rdc(OFS_ICTL, 16'h0000);
      rdc(OFS_IFLAG, 16'h0000);
      rdc(OFS_PWR, 16'h2000);
      for (i = 0; i < 8; i++) begin
         wr(OFS_LED, {i[3:0], codes[i], codes[i], codes[i], codes[i]});
         rdc(OFS_LED, {i[3:0], codes[i], codes[i], codes[i], codes[i]});
         for (j = 0; j < 3; j++) begin
            ls = pats[j];
            tick(3);
            check({8'h00, aux, led}, {8'h00, i[3:0],
               {3{led_f(codes[i], 1'b0)}}, led_f(codes[i], 1'b1)});
         end
      end
      errs(1'b1, 5);
      rdc(OFS_RXERR, 16'h0005);
      errs(1'b0, 4);
      rdc(OFS_RXERR, 16'h0005);
      wr(OFS_RXERR, 16'hfffe);
      errs(1'b1, 3);
      rdc(OFS_RXERR, 16'hffff);
      for (i = 0; i < 4; i++) begin
         wr(OFS_PWR, pw[i]);
         rdc(OFS_PWR, pw[i] & 16'hfff0);
         check({10'h000, thr}, {10'h000,
            ({2'h0, pw[i][15:12]} + 6'h03) << 1});
         check({11'h000, deep, offs}, {11'h000, pw[i][8], po[i]});
      end
      in_sleep = 1'b0;
      tick(3);
      check({12'h000, offs}, 16'h0000);
      for (i = 0; i < 11; i++) begin
         wr(OFS_ICTL, 16'h8000 | (16'h0001 << ((i + 1) % 11)));
         pulse(i);
         check({15'h0000, irq_out}, 16'h0001);
         rdc(OFS_IFLAG, 16'h0001 << i);
         wr(OFS_ICTL, 16'h8000 | (16'h0001 << i));
         check({15'h0000, irq_out}, 16'h0000);
         wr(OFS_IFLAG, 16'h0001 << i);
         check({14'h0000, irq_out, irq_oe_n}, 16'h0002);
      end
      wr(OFS_ICTL, 16'h8001);
      pulse(0);
      rdc(OFS_IFLAG, 16'h0001);
      rdc(OFS_IFLAG, 16'h0001);
      wr(OFS_ICTL, 16'hc001);
      rdc(OFS_IFLAG, 16'h0001);
      rdc(OFS_IFLAG, 16'h0000);
      check({15'h0000, irq_out}, 16'h0001);
      wr(OFS_ICTL, 16'h1000);
      evt[5] = 1'b1;
      rdc(OFS_IFLAG, 16'h0020);
      evt[5] = 1'b0;
      rdc(OFS_IFLAG, 16'h0000);
      check({15'h0000, irq_oe_n}, 16'h0001);
      evt[10] = 1'b1;
      wr(OFS_ICTL, 16'h0800);
      wr(OFS_IFLAG, 16'hfc00);
      rdc(OFS_IFLAG, 16'h0400);
      wr(OFS_ICTL, 16'h0000);
      wr(OFS_IFLAG, 16'h0400);
      rdc(OFS_IFLAG, 16'h0000);
      evt[10] = 1'b0;
      wr(OFS_ICTL, 16'ha001);
      pulse(0);
      check({14'h0000, irq_out, irq_oe_n}, 16'h0002);
      bank = 2'h1;
      rdc(OFS_ICTL, 16'hffff);
      wr(OFS_ICTL, 16'h0000);
      bank = 2'h2;
      rdc(OFS_ICTL, 16'ha001);
      rdc(5'h13, 16'hffff);
      final_report();
   end
endmodule : tb_peilp_top
